//--- inc/charger_ctrl_pkg.sv
package charger_ctrl_pkg;
  // ==========================================
  // timebase
  localparam int unsigned cnt_w            = 36;
  localparam longint      clk_hz           = 200_000_000;
  localparam longint      ns_per_s         = 1_000_000_000;
  localparam longint      us_per_s         = 1_000_000;
  localparam longint      min_pulse_ns     = 600;
  localparam longint      slow_rise_us     = 1000;
  localparam longint      alert_pulse_us   = 256;
  localparam longint      ship_hold_s      = 4;
  localparam longint      reset_hold_s     = 16;
  localparam longint      reset_open_s     = 4;
  localparam longint      watchdog_s       = 40;
  localparam logic [35:0] min_pulse_cycles    = 36'((min_pulse_ns * clk_hz + ns_per_s - 1) / ns_per_s);
  localparam logic [35:0] slow_rise_cycles_d  = 36'((slow_rise_us * clk_hz + us_per_s - 1) / us_per_s);
  localparam logic [35:0] alert_pulse_cycles_d = 36'((alert_pulse_us * clk_hz + us_per_s - 1) / us_per_s);
  localparam logic [35:0] ship_hold_cycles_d  = 36'(ship_hold_s * clk_hz);
  localparam logic [35:0] reset_hold_cycles_d = 36'(reset_hold_s * clk_hz);
  localparam logic [35:0] reset_open_cycles_d = 36'(reset_open_s * clk_hz);
  localparam logic [35:0] watchdog_cycles_d   = 36'(watchdog_s * clk_hz);
  localparam logic [1:0]  blank_cycles        = 2'h3;
  // ==========================================
  // bus and register map
  localparam logic [6:0]  target_addr      = 7'h09;
  localparam logic [7:0]  input_source_control_off   = 8'h00;
  localparam logic [7:0]  power_on_configuration_off = 8'h01;
  localparam logic [7:0]  misc_control_register_off  = 8'h06;
  localparam logic [7:0]  input_source_control_rst   = 8'h4f;
  localparam logic [7:0]  power_on_configuration_rst = 8'h04;
  localparam logic [7:0]  power_on_configuration_keep = 8'h0f;
  localparam int unsigned hiz_bit          = 7;
  localparam int unsigned floor_msb        = 6;
  localparam int unsigned floor_lsb        = 3;
  localparam int unsigned ceiling_msb      = 2;
  localparam int unsigned ceiling_lsb      = 0;
  localparam int unsigned reg_reset_bit    = 7;
  localparam int unsigned wd_restart_bit   = 6;
  localparam int unsigned inhibit_bit      = 3;
  localparam int unsigned cutoff_msb       = 2;
  localparam int unsigned cutoff_lsb       = 0;
  localparam int unsigned switch_dis_bit   = 5;
  // ==========================================
  // types
  typedef enum logic [1:0] {i2c_idle, i2c_addr, i2c_write, i2c_read} i2c_state_type;
  typedef enum logic [1:0] {pwr_normal, pwr_ship, pwr_reset} power_state_type;
  typedef struct packed {
    logic       input_high_impedance;
    logic [3:0] input_voltage_floor;
    logic [2:0] input_current_ceiling;
    logic       charge_inhibit;
    logic [2:0] battery_undervoltage_cutoff;
  } cfg_type;
endpackage

//--- verification/charger_ctrl_props.sv
`timescale 1ns/100ps
// ==========================================
// pin-level checker: power path, alert pulses, bus data timing
module charger_ctrl_props #(
  parameter logic [35:0] alert_pulse_cycles = charger_ctrl_pkg::alert_pulse_cycles_d,
  parameter logic [35:0] reset_open_cycles  = charger_ctrl_pkg::reset_open_cycles_d
) (
  input wire logic                      clock,
  input wire logic                      rst,
  input wire logic                      scl_in,
  input wire logic                      sda_oe,
  input wire logic                      alert_oe,
  input wire logic                      alert_event,
  input wire logic                      battery_switch_on,
  input wire logic                      shipping,
  input wire logic                      reset_mode,
  input wire charger_ctrl_pkg::cfg_type cfg
);
  // counters, since the spans are far too long for a repetition
  logic [35:0] oe_cnt_r;
  logic [35:0] rm_cnt_r;
  always_ff @(posedge clock) begin
    if (rst) begin
      oe_cnt_r <= '0;
      rm_cnt_r <= '0;
    end else begin
      oe_cnt_r <= alert_oe ? oe_cnt_r + 36'h1 : 36'h0;
      rm_cnt_r <= reset_mode ? rm_cnt_r + 36'h1 : 36'h0;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // ==========================================
  // assertions
  a_alert_pulse_len: assert property ($fell(alert_oe) |-> oe_cnt_r == alert_pulse_cycles)
    else $error("alert low pulse has the wrong length");
  a_alert_event_start: assert property (alert_event && !alert_oe |-> ##[1:2] alert_oe)
    else $error("alert pulse missing after an event");
  a_ship_switch_open: assert property (shipping |-> !battery_switch_on && !reset_mode)
    else $error("battery switch closed while shipping");
  a_reset_switch_open: assert property (reset_mode |-> !battery_switch_on)
    else $error("battery switch closed in reset mode");
  a_reset_open_span: assert property ($fell(reset_mode) |->
    rm_cnt_r >= reset_open_cycles && rm_cnt_r <= reset_open_cycles + 36'd2)
    else $error("reset mode span is wrong");
  a_reset_switch_close: assert property ($fell(reset_mode) |-> ##[0:1] battery_switch_on)
    else $error("switch not closed after reset mode");
  a_sda_low_phase: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data line moved while clock high");
  a_cfg_defaults: assert property ($fell(rst) |-> cfg == 12'h4f4)
    else $error("configuration not at defaults after reset");
  // leaving shipping straight into reset mode keeps the switch open, so that exit is excluded
  a_ship_exit_close: assert property ($fell(shipping) && !reset_mode |-> ##[0:1] battery_switch_on)
    else $error("switch not closed on leaving shipping");
  cover property ($rose(shipping));
  cover property ($fell(shipping));
  cover property ($rose(reset_mode));
  cover property ($rose(alert_oe));
endmodule // charger_ctrl_props

bind charger_i2c_ship_reset_ctrl charger_ctrl_props #(
  .alert_pulse_cycles(alert_pulse_cycles), .reset_open_cycles(reset_open_cycles)
) charger_ctrl_props_inst (
  .clock(clock), .rst(rst), .scl_in(scl_in), .sda_oe(sda_oe), .alert_oe(alert_oe),
  .alert_event(alert_event), .battery_switch_on(battery_switch_on), .shipping(shipping),
  .reset_mode(reset_mode), .cfg(cfg)
);

//--- verification/charger_i2c_ship_reset_ctrl_tb.sv
`timescale 1ns/100ps
`define CHK(what, exp, got) begin n_tests++; if ((got) !== (exp)) begin fails++; \
  $display("unexpected %s expected %h seen %h", what, exp, got); end end
module charger_i2c_ship_reset_ctrl_tb;
  // ==========================================
  // clock, pins and counters
  logic                      clock = 1'b0;
  logic                      rst = 1'b1;
  logic                      alert_drv = 1'b1;
  logic                      vin_good = 1'b0;
  logic                      alert_event = 1'b0;
  logic                      scl;
  logic                      host_sda;
  logic                      sda_oe;
  logic                      sda_out;
  logic                      alert_oe;
  logic                      alert_out;
  logic                      host_mode;
  logic                      battery_switch_on;
  logic                      shipping;
  logic                      reset_mode;
  charger_ctrl_pkg::cfg_type cfg;
  int                        fails = 0;
  int                        n_tests = 0;
  // pull-ups: a line reads high unless some party pulls it low
  wire logic                 sda_bus = host_sda & (~sda_oe | sda_out);
  wire logic                 alert_in = alert_drv & (~alert_oe | alert_out);
  // short spans keep the run small; they are set freely, not in the ratios of the real timebase
  localparam logic [35:0]    ship_hold  = 36'd2000;
  localparam logic [35:0]    reset_hold = 36'd6000;
  localparam logic [35:0]    reset_open = 36'd1000;
  localparam logic [35:0]    slow_rise  = 36'd500;
  localparam logic [35:0]    alert_len  = 36'd100;
  localparam logic [35:0]    wd_limit   = 36'd3000;
  always #2.5 clock = ~clock;
  charger_i2c_ship_reset_ctrl #(
    .ship_hold_cycles(ship_hold), .reset_hold_cycles(reset_hold), .reset_open_cycles(reset_open),
    .slow_rise_cycles(slow_rise), .alert_pulse_cycles(alert_len), .watchdog_cycles(wd_limit)
  ) charger_i2c_ship_reset_ctrl_inst (
    .clock(clock), .rst(rst), .scl_in(scl), .sda_in(sda_bus), .sda_out(sda_out), .sda_oe(sda_oe),
    .alert_in(alert_in), .alert_out(alert_out), .alert_oe(alert_oe), .vin_good(vin_good),
    .alert_event(alert_event), .battery_switch_on(battery_switch_on), .shipping(shipping),
    .reset_mode(reset_mode), .host_mode(host_mode), .cfg(cfg)
  );
  i2c_host_model i2c_host_model_inst (.clock(clock), .sda_bus(sda_bus), .scl(scl), .sda(host_sda));
  // ==========================================
  // access tasks
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic tx(input logic [7:0] b, input logic exp_ack);
    logic [7:0] rx;
    logic       ack_n;
    i2c_host_model_inst.byte_io(b, 1'b1, rx, ack_n);
    `CHK("acknowledge", exp_ack, !ack_n)
  endtask
  task automatic wr(input logic [7:0] idx, input logic [15:0] d, input int n);
    i2c_host_model_inst.start();
    tx({7'h09, 1'b0}, 1'b1);
    tx(idx, 1'b1);
    for (int i = 0; i < n; i++) tx(d[15-8*i -: 8], 1'b1);
    i2c_host_model_inst.stop();
    wt(4);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] rx;
    logic       ack_n;
    i2c_host_model_inst.start();
    tx({7'h09, 1'b0}, 1'b1);
    tx(idx, 1'b1);
    i2c_host_model_inst.start();
    tx({7'h09, 1'b1}, 1'b1);
    i2c_host_model_inst.byte_io(8'hff, 1'b1, rx, ack_n);
    i2c_host_model_inst.stop();
    `CHK("read data", exp, rx)
    wt(4);
  endtask
  task automatic low(input int n);
    alert_drv <= 1'b0;
    wt(n);
    alert_drv <= 1'b1;
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // a hang ends here as a mismatch
  initial begin
    wt(90000);
    fails++;
    final_report();
  end
  // ==========================================
  // scenarios
  initial begin
    wt(8);
    rst <= 1'b0;
    wt(4);
    `CHK("cfg", 12'h4f4, cfg)
    rd(8'h00, 8'h4f);
    rd(8'h01, 8'h04);
    wr(8'h00, 16'hb20d, 2);
    `CHK("cfg", 12'hb2d, cfg)
    wr(8'h01, 16'h4d00, 1);
    rd(8'h01, 8'h0d);
    i2c_host_model_inst.start();
    tx({7'h0a, 1'b0}, 1'b0);
    i2c_host_model_inst.stop();
    wr(8'h01, 16'h8000, 1);
    `CHK("cfg", 12'h4f4, cfg)
    `CHK("host mode", 1'b0, host_mode)
    wr(8'h06, 16'h2000, 1);
    `CHK("switch", 1'b0, battery_switch_on)
    `CHK("shipping", 1'b1, shipping)
    rd(8'h06, 8'h00);
    vin_good <= 1'b1;
    wt(8);
    `CHK("alert drive", 1'b1, alert_oe)
    wt(150);
    low(200);
    wt(60);
    low(200);
    wt(10);
    `CHK("shipping", 1'b0, shipping)
    vin_good <= 1'b0;
    wr(8'h06, 16'h2000, 1);
    low(200);
    wt(1000);
    `CHK("shipping", 1'b1, shipping)
    wt(1100);
    `CHK("shipping", 1'b0, shipping)
    wr(8'h06, 16'h2000, 1);
    low(600);
    wt(10);
    `CHK("shipping", 1'b0, shipping)
    wr(8'h06, 16'h2000, 1);
    wr(8'h06, 16'h2000, 1);
    low(2050);
    `CHK("shipping", 1'b0, shipping)
    rd(8'h06, 8'h20);
    wr(8'h06, 16'h0000, 1);
    wr(8'h06, 16'h2000, 1);
    alert_drv <= 1'b0;
    wt(2050);
    `CHK("shipping", 1'b0, shipping)
    `CHK("switch", 1'b1, battery_switch_on)
    low(4000);
    `CHK("reset mode", 1'b1, reset_mode)
    `CHK("switch", 1'b0, battery_switch_on)
    wt(900);
    `CHK("switch", 1'b0, battery_switch_on)
    wt(120);
    `CHK("switch", 1'b1, battery_switch_on)
    alert_event <= 1'b1;
    wt(1);
    alert_event <= 1'b0;
    wt(4);
    `CHK("alert drive", 1'b1, alert_oe)
    wt(100);
    `CHK("alert drive", 1'b0, alert_oe)
    vin_good <= 1'b1;
    wr(8'h00, 16'hb200, 1);
    wr(8'h01, 16'h4400, 1);
    wt(2500);
    `CHK("host mode", 1'b1, host_mode)
    wt(700);
    `CHK("host mode", 1'b0, host_mode)
    `CHK("cfg", 12'h4f4, cfg)
    final_report();
  end
endmodule // charger_i2c_ship_reset_ctrl_tb

//--- verification/i2c_host_model.sv
`timescale 1ns/100ps
// ==========================================
// bus host; its clock stands still high between frames
module i2c_host_model (
  input  wire logic clock,
  input  wire logic sda_bus,
  output logic      scl,
  output logic      sda
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clock);
  endtask
  // data moves halfway into the low phase, clear of both clock edges
  task automatic bit_io(input logic b, output logic s);
    w(4);
    sda <= b;
    w(4);
    scl <= 1'b1;
    w(4);
    s = sda_bus;
    w(4);
    scl <= 1'b0;
  endtask
  // the first wait lets a clock fall scheduled by the caller land before scl is read
  task automatic start();
    w(1);
    if (!scl) begin
      w(3);
      sda <= 1'b1;
      w(4);
      scl <= 1'b1;
      w(8);
    end
    sda <= 1'b0;
    w(8);
    scl <= 1'b0;
  endtask
  task automatic stop();
    w(4);
    sda <= 1'b0;
    w(4);
    scl <= 1'b1;
    w(8);
    sda <= 1'b1;
    w(8);
  endtask
  task automatic byte_io(input logic [7:0] b, input logic ack_bit, output logic [7:0] rx, output logic ack_n);
    for (int i = 7; i >= 0; i--) bit_io(b[i], rx[i]);
    bit_io(ack_bit, ack_n);
  endtask
endmodule // i2c_host_model

//--- verilog/charger_i2c_ship_reset_ctrl.sv
`timescale 1ns/100ps
module charger_i2c_ship_reset_ctrl #(
  parameter logic [35:0] ship_hold_cycles   = charger_ctrl_pkg::ship_hold_cycles_d,
  parameter logic [35:0] reset_hold_cycles  = charger_ctrl_pkg::reset_hold_cycles_d,
  parameter logic [35:0] reset_open_cycles  = charger_ctrl_pkg::reset_open_cycles_d,
  parameter logic [35:0] slow_rise_cycles   = charger_ctrl_pkg::slow_rise_cycles_d,
  parameter logic [35:0] alert_pulse_cycles = charger_ctrl_pkg::alert_pulse_cycles_d,
  parameter logic [35:0] watchdog_cycles    = charger_ctrl_pkg::watchdog_cycles_d
) (
  input  wire logic                      clock,
  input  wire logic                      rst,
  input  wire logic                      scl_in,
  input  wire logic                      sda_in,
  output logic                           sda_out,
  output logic                           sda_oe,
  input  wire logic                      alert_in,
  output logic                           alert_out,
  output logic                           alert_oe,
  input  wire logic                      vin_good,
  input  wire logic                      alert_event,
  output logic                           battery_switch_on,
  output logic                           shipping,
  output logic                           reset_mode,
  output logic                           host_mode,
  output charger_ctrl_pkg::cfg_type      cfg
);

  // ==========================================
  // state
  typedef struct packed {
    logic [2:0]                        scl_s;
    logic [2:0]                        sda_s;
    logic [1:0]                        alert_s;
    logic [1:0]                        vin_s;
    logic                              vin_prev;
    charger_ctrl_pkg::i2c_state_type   i2c;
    logic [3:0]                        bit_cnt;
    logic [7:0]                        shift;
    logic                              rw;
    logic                              first;
    logic [7:0]                        idx;
    logic                              sda_drive;
    logic [7:0]                        r00;
    logic [7:0]                        r01;
    logic                              dis;
    charger_ctrl_pkg::power_state_type pwr;
    logic                              sw_on;
    logic                              auto_clr;
    logic                              persist;
    logic                              pend;
    logic [35:0]                       low_cnt;
    logic [35:0]                       wait_cnt;
    logic                              prev_low;
    logic [35:0]                       pulse_cnt;
    logic [1:0]                        blank;
    logic                              host;
    logic [35:0]                       wd_cnt;
  } state_type;

  localparam state_type state_rst = '{
    scl_s: 3'h7, sda_s: 3'h7, alert_s: 2'h3,
    i2c: charger_ctrl_pkg::i2c_idle, pwr: charger_ctrl_pkg::pwr_normal,
    r00: charger_ctrl_pkg::input_source_control_rst,
    r01: charger_ctrl_pkg::power_on_configuration_rst,
    sw_on: 1'h1, default: '0};

  state_type s_r;
  state_type s_nxt;
  logic      scl_rise;
  logic      scl_fall;
  logic      start_seen;
  logic      stop_seen;
  logic      ship_req;
  logic      alert_low;
  logic      alert_rise;
  logic      go_normal;

  // ==========================================
  // register read decode
  function automatic logic [7:0] reg_read(input logic [7:0] a, input state_type s);
    case (a)
      charger_ctrl_pkg::input_source_control_off:   reg_read = s.r00;
      charger_ctrl_pkg::power_on_configuration_off: reg_read = s.r01;
      charger_ctrl_pkg::misc_control_register_off:  reg_read = {2'h0, s.dis, 5'h00};
      default:                                      reg_read = 8'h00;
    endcase
  endfunction

  always_comb begin
    s_nxt      = s_r;
    ship_req   = 1'h0;
    go_normal  = 1'h0;
    // ==========================================
    // synchronisers, the first stage feeds only the second
    s_nxt.scl_s   = {s_r.scl_s[1:0], scl_in};
    s_nxt.sda_s   = {s_r.sda_s[1:0], sda_in};
    s_nxt.alert_s = {s_r.alert_s[0], alert_in};
    s_nxt.vin_s   = {s_r.vin_s[0], vin_good};
    s_nxt.vin_prev = s_r.vin_s[1];
    scl_rise   = s_r.scl_s[1] && !s_r.scl_s[2];
    scl_fall   = !s_r.scl_s[1] && s_r.scl_s[2];
    start_seen = s_r.scl_s[1] && s_r.scl_s[2] && s_r.sda_s[2] && !s_r.sda_s[1];
    stop_seen  = s_r.scl_s[1] && s_r.scl_s[2] && !s_r.sda_s[2] && s_r.sda_s[1];

    // ==========================================
    // i2c target; scl is only ever sampled, never driven
    if (start_seen) begin
      s_nxt.i2c       = charger_ctrl_pkg::i2c_addr;
      s_nxt.bit_cnt   = 4'h0;
      s_nxt.first     = 1'h1;
      s_nxt.sda_drive = 1'h0;
    end else if (stop_seen) begin
      s_nxt.i2c       = charger_ctrl_pkg::i2c_idle;
      s_nxt.sda_drive = 1'h0;
    end else if (s_r.i2c != charger_ctrl_pkg::i2c_idle && scl_rise) begin
      if (s_r.bit_cnt < 4'h8 && s_r.i2c != charger_ctrl_pkg::i2c_read) begin
        s_nxt.shift = {s_r.shift[6:0], s_r.sda_s[1]};
      end
      if (s_r.i2c == charger_ctrl_pkg::i2c_read && s_r.bit_cnt == 4'h8 && s_r.sda_s[1]) begin
        s_nxt.i2c = charger_ctrl_pkg::i2c_idle;
      end
      s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
    end else if (s_r.i2c != charger_ctrl_pkg::i2c_idle && scl_fall) begin
      case (s_r.i2c)
        charger_ctrl_pkg::i2c_addr: begin
          if (s_r.bit_cnt == 4'h8) begin
            if (s_r.shift[7:1] == charger_ctrl_pkg::target_addr) begin
              s_nxt.sda_drive = 1'h1;
              s_nxt.rw        = s_r.shift[0];
            end else begin
              s_nxt.i2c = charger_ctrl_pkg::i2c_idle;
            end
          end else if (s_r.bit_cnt == 4'h9) begin
            s_nxt.bit_cnt = 4'h0;
            if (s_r.rw) begin
              s_nxt.i2c       = charger_ctrl_pkg::i2c_read;
              s_nxt.shift     = reg_read(s_r.idx, s_r);
              s_nxt.sda_drive = !s_nxt.shift[7];
              s_nxt.idx       = s_r.idx + 8'h1;
            end else begin
              s_nxt.i2c       = charger_ctrl_pkg::i2c_write;
              s_nxt.sda_drive = 1'h0;
            end
          end
        end
        charger_ctrl_pkg::i2c_write: begin
          if (s_r.bit_cnt == 4'h8) begin
            s_nxt.sda_drive = 1'h1;
            if (s_r.first) begin
              s_nxt.first = 1'h0;
              s_nxt.idx   = s_r.shift;
            end else begin
              s_nxt.idx  = s_r.idx + 8'h1;
              s_nxt.host = 1'h1;
              case (s_r.idx)
                charger_ctrl_pkg::input_source_control_off: begin
                  s_nxt.r00 = s_r.shift;
                end
                charger_ctrl_pkg::power_on_configuration_off: begin
                  s_nxt.r01 = s_r.shift & charger_ctrl_pkg::power_on_configuration_keep;
                  if (s_r.shift[charger_ctrl_pkg::wd_restart_bit]) begin
                    s_nxt.wd_cnt = '0;
                  end
                  if (s_r.shift[charger_ctrl_pkg::reg_reset_bit]) begin
                    s_nxt.r00  = charger_ctrl_pkg::input_source_control_rst;
                    s_nxt.r01  = charger_ctrl_pkg::power_on_configuration_rst;
                    s_nxt.dis  = 1'h0;
                    s_nxt.host = 1'h0;
                  end
                end
                charger_ctrl_pkg::misc_control_register_off: begin
                  s_nxt.dis = s_r.shift[charger_ctrl_pkg::switch_dis_bit];
                  if (s_r.shift[charger_ctrl_pkg::switch_dis_bit]) begin
                    if (s_r.pwr == charger_ctrl_pkg::pwr_ship) begin
                      s_nxt.persist = 1'h1;
                    end else begin
                      ship_req = 1'h1;
                    end
                  end
                end
                default: begin
                end
              endcase
            end
          end else if (s_r.bit_cnt == 4'h9) begin
            s_nxt.sda_drive = 1'h0;
            s_nxt.bit_cnt   = 4'h0;
          end
        end
        charger_ctrl_pkg::i2c_read: begin
          if (s_r.bit_cnt == 4'h8) begin
            s_nxt.sda_drive = 1'h0;
          end else if (s_r.bit_cnt == 4'h9) begin
            s_nxt.bit_cnt   = 4'h0;
            s_nxt.shift     = reg_read(s_r.idx, s_r);
            s_nxt.sda_drive = !s_nxt.shift[7];
            s_nxt.idx       = s_r.idx + 8'h1;
          end else if (s_r.bit_cnt != 4'h0) begin
            s_nxt.shift     = {s_r.shift[6:0], 1'h0};
            s_nxt.sda_drive = !s_r.shift[6];
          end
        end
        default: begin
          s_nxt.i2c = charger_ctrl_pkg::i2c_idle;
        end
      endcase
    end

    // ==========================================
    // watchdog, suspended without input power
    if (s_r.host && s_r.vin_s[1]) begin
      s_nxt.wd_cnt = s_nxt.wd_cnt + 36'h1;
      if (s_r.wd_cnt >= watchdog_cycles) begin
        s_nxt.r00    = charger_ctrl_pkg::input_source_control_rst;
        s_nxt.r01    = charger_ctrl_pkg::power_on_configuration_rst;
        s_nxt.host   = 1'h0;
        s_nxt.wd_cnt = '0;
      end
    end

    // ==========================================
    // alert driver; blanking covers our own pulse plus sync latency
    if (s_r.pulse_cnt != '0) begin
      s_nxt.pulse_cnt = s_r.pulse_cnt - 36'h1;
    end
    if (alert_event) begin
      s_nxt.pulse_cnt = alert_pulse_cycles;
    end
    if (s_r.pwr == charger_ctrl_pkg::pwr_ship && s_r.vin_s[1] && !s_r.vin_prev) begin
      s_nxt.pulse_cnt = alert_pulse_cycles;
    end
    if (s_r.pulse_cnt != '0) begin
      s_nxt.blank = charger_ctrl_pkg::blank_cycles;
    end else if (s_r.blank != 2'h0) begin
      s_nxt.blank = s_r.blank - 2'h1;
    end
    alert_low      = !s_r.alert_s[1] && s_r.pulse_cnt == '0 && s_r.blank == 2'h0;
    alert_rise     = s_r.prev_low && !alert_low && s_r.pulse_cnt == '0 && s_r.blank == 2'h0;
    s_nxt.prev_low = alert_low;
    if (!alert_low) begin
      s_nxt.low_cnt = '0;
    end else if (s_r.low_cnt != '1) begin
      s_nxt.low_cnt = s_r.low_cnt + 36'h1;
    end

    // ==========================================
    // battery switch sequencing
    case (s_r.pwr)
      charger_ctrl_pkg::pwr_normal: begin
        if (ship_req) begin
          s_nxt.sw_on    = 1'h0;
          s_nxt.pwr      = charger_ctrl_pkg::pwr_ship;
          s_nxt.auto_clr = 1'h1;
          s_nxt.pend     = 1'h0;
        end
      end
      charger_ctrl_pkg::pwr_ship: begin
        if (s_r.auto_clr && !s_r.sw_on) begin
          s_nxt.auto_clr = 1'h0;
          if (!s_nxt.persist) begin
            s_nxt.dis = 1'h0;
          end
        end
        if (s_r.persist || s_nxt.persist) begin
          go_normal = alert_low && s_r.low_cnt >= ship_hold_cycles;
        end else if (alert_low && s_r.low_cnt >= ship_hold_cycles) begin
          go_normal = 1'h1;
        end else if (alert_rise && s_r.low_cnt >= slow_rise_cycles) begin
          go_normal = 1'h1;
        end else if (alert_rise && s_r.low_cnt > charger_ctrl_pkg::min_pulse_cycles) begin
          go_normal      = s_r.pend;
          s_nxt.pend     = 1'h1;
          s_nxt.wait_cnt = '0;
        end else if (s_r.pend) begin
          s_nxt.wait_cnt = s_r.wait_cnt + 36'h1;
          go_normal      = s_r.wait_cnt >= ship_hold_cycles;
        end
      end
      charger_ctrl_pkg::pwr_reset: begin
        s_nxt.wait_cnt = s_r.wait_cnt + 36'h1; // alert level ignored here
        if (s_r.wait_cnt >= reset_open_cycles) begin
          go_normal     = 1'h1;
          s_nxt.low_cnt = '0;
        end
      end
      default: begin
        s_nxt.pwr = charger_ctrl_pkg::pwr_normal;
      end
    endcase
    if (go_normal) begin
      s_nxt.pwr      = charger_ctrl_pkg::pwr_normal;
      s_nxt.sw_on    = 1'h1;
      s_nxt.pend     = 1'h0;
      s_nxt.persist  = 1'h0;
      s_nxt.auto_clr = 1'h0;
    end
    if (s_r.pwr != charger_ctrl_pkg::pwr_reset && alert_low && s_r.low_cnt > reset_hold_cycles) begin
      s_nxt.pwr      = charger_ctrl_pkg::pwr_reset;
      s_nxt.sw_on    = 1'h0;
      s_nxt.wait_cnt = '0;
      s_nxt.pend     = 1'h0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_r <= state_rst;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================
  // outputs
  assign sda_out           = 1'h0;
  assign sda_oe            = s_r.sda_drive;
  assign alert_out         = 1'h0;
  assign alert_oe          = s_r.pulse_cnt != '0;
  assign battery_switch_on = s_r.sw_on;
  assign shipping          = s_r.pwr == charger_ctrl_pkg::pwr_ship;
  assign reset_mode        = s_r.pwr == charger_ctrl_pkg::pwr_reset;
  assign host_mode         = s_r.host;
  assign cfg.input_high_impedance        = s_r.r00[charger_ctrl_pkg::hiz_bit];
  assign cfg.input_voltage_floor         = s_r.r00[charger_ctrl_pkg::floor_msb:charger_ctrl_pkg::floor_lsb];
  assign cfg.input_current_ceiling       = s_r.r00[charger_ctrl_pkg::ceiling_msb:charger_ctrl_pkg::ceiling_lsb];
  assign cfg.charge_inhibit              = s_r.r01[charger_ctrl_pkg::inhibit_bit];
  assign cfg.battery_undervoltage_cutoff = s_r.r01[charger_ctrl_pkg::cutoff_msb:charger_ctrl_pkg::cutoff_lsb];

endmodule // charger_i2c_ship_reset_ctrl
